// ==== inc/afe_cfg_pkg.sv ====
package afe_cfg_pkg;
   // register indices (printed offsets), byte address = 4 * index
   localparam logic [3:0] IDX_POWER_TRIM  = 4'h3;
   localparam logic [3:0] IDX_CLAMP_REF   = 4'h4;
   localparam logic [3:0] IDX_SERIAL_OUT  = 4'h5;
   localparam logic [3:0] IDX_SAMPLE_HOLD = 4'h6;
   localparam logic [3:0] IDX_LOCK_STATUS = 4'h7;
   localparam logic [3:0] IDX_PROBE_SEL   = 4'h9;
   localparam logic [3:0] IDX_IRQ_STATUS  = 4'hA;
   localparam logic [3:0] IDX_IRQ_MASK    = 4'hB;

   // values after reset (baseline)
   localparam logic [7:0] RST_POWER_TRIM  = 8'h5B;
   localparam logic [7:0] RST_CLAMP_REF   = 8'h74;
   localparam logic [7:0] RST_SERIAL_OUT  = 8'h0E;
   localparam logic [7:0] RST_SAMPLE_HOLD = 8'h81;
   localparam logic [7:0] RST_PROBE_SEL   = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK    = 8'h00;

   // writable bit masks; other bits read zero
   localparam logic [7:0] WMASK_POWER_TRIM  = 8'hFF;
   localparam logic [7:0] WMASK_CLAMP_REF   = 8'h7F;
   localparam logic [7:0] WMASK_SERIAL_OUT  = 8'h8F;
   localparam logic [7:0] WMASK_SAMPLE_HOLD = 8'h87;
   localparam logic [7:0] WMASK_PROBE_SEL   = 8'h1F;
   localparam logic [7:0] WMASK_IRQ         = 8'h01;

   // field positions
   localparam int TRIM_A_LSB    = 3;
   localparam int TRIM_B_LSB    = 0;
   localparam int CLAMP_BUF_BIT = 6;
   localparam int CLAMP_EN_BIT  = 5;
   localparam int SER_RST_BIT   = 7;
   localparam int SER_QUAD_BIT  = 3;
   localparam int SER_DRV_BIT   = 2;
   localparam int SH_EN_BIT     = 7;
   localparam int REFBUF_LSB    = 1;
   localparam int PROBE_LSB     = 3;

   // clamp reference level codes
   localparam logic [4:0] CLAMP_CODE_MAX = 5'h1D;

   typedef enum logic [1:0] {PWR_QUARTER, PWR_HALF, PWR_THREE_QUARTER, PWR_FULL} power_level_e;
   typedef enum logic [1:0] {REFBUF_30, REFBUF_60, REFBUF_100} refbuf_level_e;
   typedef enum logic [1:0] {PROBE_OFF, PROBE_EVEN, PROBE_ODD, PROBE_TAG_CLK} probe_mode_e;
endpackage

// ==== hdl/afe_config_status_registers.sv ====
`timescale 1ns/1ps
module afe_config_status_registers (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // internal timing pulses and lock detector
   input  wire logic        false_lock_in,
   input  wire logic        clamp_even,
   input  wire logic        sample_even,
   input  wire logic        clamp_odd,
   input  wire logic        sample_odd,
   input  wire logic        odd_tag,
   input  wire logic        converter_clock,
   // analog controls
   output logic [1:0]       trim_a_level,
   output logic [1:0]       trim_b_level,
   output logic             clamp_ref_buffered,
   output logic             clamp_reference_pin_oe,
   output logic [4:0]       clamp_ref_level,
   output logic             clamp_ref_code_valid,
   output logic             serializer_reset,
   output logic             quad_lane_mode,
   output logic             first_serial_lane_en,
   output logic             middle_serial_lanes_en,
   output logic             fourth_serial_lane_en,
   output logic [1:0]       swing_select,
   output logic             sample_hold_en,
   output logic [1:0]       refbuf_level,
   output logic             timing_probe_pin_a,
   output logic             timing_probe_pin_b,
   // interrupt
   output logic             irq
);
   // non-binary trim decode
   function automatic logic [1:0] trim_decode(input logic [2:0] code);
      logic [1:0] r;
      r = afe_cfg_pkg::PWR_QUARTER;
      if (code == 3'h7) begin
         r = afe_cfg_pkg::PWR_FULL;
      end else if (code[1]) begin
         r = afe_cfg_pkg::PWR_THREE_QUARTER;
      end else if (code[0]) begin
         r = afe_cfg_pkg::PWR_HALF;
      end
      return r;
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      return (old & ~m) | (wd & m);
   endfunction

   logic [7:0] trim_reg, trim_next;
   logic [7:0] clamp_reg, clamp_next;
   logic [7:0] ser_reg, ser_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] probe_reg, probe_next;
   logic [7:0] lock_reg, lock_next;
   logic [7:0] irq_stat_reg, irq_stat_next;
   logic [7:0] irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_next;
   logic        ready_next;
   logic        err_next;
   logic        access;
   logic        wr;
   logic        rd;
   logic        lock_prev_reg;
   logic [3:0]  idx;
   logic        mapped;
   logic        word_ok;
   logic [7:0]  rd_byte;

   assign access = psel & penable & ~pready;
   assign idx    = paddr[5:2];
   assign word_ok = (paddr[1:0] == 2'h0) & (paddr[7:6] == 2'h0);
   assign wr     = psel & penable & pready & pwrite & pstrb[0];
   assign rd     = access & ~pwrite;

   always_comb begin
      mapped  = word_ok;
      rd_byte = 8'h00;
      if (idx == afe_cfg_pkg::IDX_POWER_TRIM) begin
         rd_byte = trim_reg;
      end else if (idx == afe_cfg_pkg::IDX_CLAMP_REF) begin
         rd_byte = clamp_reg;
      end else if (idx == afe_cfg_pkg::IDX_SERIAL_OUT) begin
         rd_byte = ser_reg;
      end else if (idx == afe_cfg_pkg::IDX_SAMPLE_HOLD) begin
         rd_byte = sh_reg;
      end else if (idx == afe_cfg_pkg::IDX_LOCK_STATUS) begin
         rd_byte = lock_reg;
      end else if (idx == afe_cfg_pkg::IDX_PROBE_SEL) begin
         rd_byte = probe_reg;
      end else if (idx == afe_cfg_pkg::IDX_IRQ_STATUS) begin
         rd_byte = irq_stat_reg;
      end else if (idx == afe_cfg_pkg::IDX_IRQ_MASK) begin
         rd_byte = irq_mask_reg;
      end else begin
         mapped = 1'b0;
      end
   end

   // register file next state
   always_comb begin
      trim_next     = trim_reg;
      clamp_next    = clamp_reg;
      ser_next      = ser_reg;
      sh_next       = sh_reg;
      probe_next    = probe_reg;
      irq_mask_next = irq_mask_reg;
      lock_next     = {7'h00, false_lock_in};
      irq_stat_next = irq_stat_reg;
      if (wr && mapped) begin
         if (idx == afe_cfg_pkg::IDX_POWER_TRIM) begin
            trim_next = merge(trim_reg, pwdata[7:0], afe_cfg_pkg::WMASK_POWER_TRIM);
         end else if (idx == afe_cfg_pkg::IDX_CLAMP_REF) begin
            clamp_next = merge(clamp_reg, pwdata[7:0], afe_cfg_pkg::WMASK_CLAMP_REF);
         end else if (idx == afe_cfg_pkg::IDX_SERIAL_OUT) begin
            ser_next = merge(ser_reg, pwdata[7:0], afe_cfg_pkg::WMASK_SERIAL_OUT);
         end else if (idx == afe_cfg_pkg::IDX_SAMPLE_HOLD) begin
            sh_next = merge(sh_reg, pwdata[7:0], afe_cfg_pkg::WMASK_SAMPLE_HOLD);
         end else if (idx == afe_cfg_pkg::IDX_PROBE_SEL) begin
            probe_next = merge(probe_reg, pwdata[7:0], afe_cfg_pkg::WMASK_PROBE_SEL);
         end else if (idx == afe_cfg_pkg::IDX_IRQ_MASK) begin
            irq_mask_next = merge(irq_mask_reg, pwdata[7:0], afe_cfg_pkg::WMASK_IRQ);
         end
      end
      // read clears, a new event in the same cycle wins
      if (rd && mapped && idx == afe_cfg_pkg::IDX_IRQ_STATUS) begin
         irq_stat_next = 8'h00;
      end
      if (false_lock_in && !lock_prev_reg) begin
         irq_stat_next[0] = 1'b1;
      end
   end

   // bus answer, one wait state
   always_comb begin
      ready_next = access;
      err_next   = access & ~mapped;
      rdata_next = 32'h0000_0000;
      if (rd && mapped) begin
         rdata_next = {24'h00_0000, rd_byte};
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_reg  <= afe_cfg_pkg::RST_POWER_TRIM;
         clamp_reg <= afe_cfg_pkg::RST_CLAMP_REF;
         ser_reg   <= afe_cfg_pkg::RST_SERIAL_OUT;
         sh_reg    <= afe_cfg_pkg::RST_SAMPLE_HOLD;
         probe_reg <= afe_cfg_pkg::RST_PROBE_SEL;
      end else begin
         trim_reg  <= trim_next;
         clamp_reg <= clamp_next;
         ser_reg   <= ser_next;
         sh_reg    <= sh_next;
         probe_reg <= probe_next;
      end
   end

   // lock status and interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg      <= 8'h00;
         irq_stat_reg  <= 8'h00;
         irq_mask_reg  <= afe_cfg_pkg::RST_IRQ_MASK;
         lock_prev_reg <= 1'b0;
      end else begin
         lock_reg      <= lock_next;
         irq_stat_reg  <= irq_stat_next;
         irq_mask_reg  <= irq_mask_next;
         lock_prev_reg <= false_lock_in;
      end
   end

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= rdata_next;
         pready  <= ready_next;
         pslverr <= err_next;
      end
   end

   // decoded controls, registered
   logic [1:0] trim_a_next;
   logic [1:0] trim_b_next;
   logic [1:0] refbuf_next;
   logic       probe_a_next;
   logic       probe_b_next;
   logic       drv_on;
   logic       quad;
   logic       buffered_next;
   logic       pin_oe_next;
   logic [4:0] level_next;
   logic       code_valid_next;
   logic       ser_rst_next;
   logic       quad_next;
   logic       first_en_next;
   logic       middle_en_next;
   logic       fourth_en_next;
   logic [1:0] swing_next;
   logic       sh_en_next;
   logic       irq_next;

   always_comb begin
      trim_a_next = trim_decode(trim_reg[afe_cfg_pkg::TRIM_A_LSB +: 3]);
      trim_b_next = trim_decode(trim_reg[afe_cfg_pkg::TRIM_B_LSB +: 3]);
      quad        = ser_reg[afe_cfg_pkg::SER_QUAD_BIT];
      drv_on      = ser_reg[afe_cfg_pkg::SER_DRV_BIT];
      buffered_next   = clamp_reg[afe_cfg_pkg::CLAMP_BUF_BIT];
      pin_oe_next     = clamp_reg[afe_cfg_pkg::CLAMP_EN_BIT];
      level_next      = clamp_reg[4:0];
      code_valid_next = clamp_reg[4:0] <= afe_cfg_pkg::CLAMP_CODE_MAX;
      ser_rst_next    = ser_reg[afe_cfg_pkg::SER_RST_BIT];
      quad_next       = quad;
      first_en_next   = drv_on & quad;
      middle_en_next  = drv_on;
      fourth_en_next  = drv_on & quad;
      swing_next      = ser_reg[1:0];
      sh_en_next      = sh_reg[afe_cfg_pkg::SH_EN_BIT];
      irq_next        = |(irq_stat_reg & irq_mask_reg);
      case (sh_reg[afe_cfg_pkg::REFBUF_LSB +: 2])
         2'h3:    refbuf_next = afe_cfg_pkg::REFBUF_100;
         2'h0:    refbuf_next = afe_cfg_pkg::REFBUF_30;
         default: refbuf_next = afe_cfg_pkg::REFBUF_60;
      endcase
      case (probe_reg[afe_cfg_pkg::PROBE_LSB +: 2])
         afe_cfg_pkg::PROBE_EVEN: begin
            probe_a_next = clamp_even;
            probe_b_next = sample_even;
         end
         afe_cfg_pkg::PROBE_ODD: begin
            probe_a_next = clamp_odd;
            probe_b_next = sample_odd;
         end
         afe_cfg_pkg::PROBE_TAG_CLK: begin
            probe_a_next = odd_tag;
            probe_b_next = converter_clock;
         end
         default: begin
            probe_a_next = 1'b0;
            probe_b_next = 1'b0;
         end
      endcase
   end

   // analog control outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_a_level           <= afe_cfg_pkg::PWR_THREE_QUARTER;
         trim_b_level           <= afe_cfg_pkg::PWR_THREE_QUARTER;
         clamp_ref_buffered     <= 1'b1;
         clamp_reference_pin_oe <= 1'b1;
         clamp_ref_level        <= 5'h14;
         clamp_ref_code_valid   <= 1'b1;
         sample_hold_en         <= 1'b1;
         refbuf_level           <= afe_cfg_pkg::REFBUF_30;
      end else begin
         trim_a_level           <= trim_a_next;
         trim_b_level           <= trim_b_next;
         clamp_ref_buffered     <= buffered_next;
         clamp_reference_pin_oe <= pin_oe_next;
         clamp_ref_level        <= level_next;
         clamp_ref_code_valid   <= code_valid_next;
         sample_hold_en         <= sh_en_next;
         refbuf_level           <= refbuf_next;
      end
   end

   // serial output controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serializer_reset       <= 1'b0;
         quad_lane_mode         <= 1'b1;
         first_serial_lane_en   <= 1'b1;
         middle_serial_lanes_en <= 1'b1;
         fourth_serial_lane_en  <= 1'b1;
         swing_select           <= 2'h2;
      end else begin
         serializer_reset       <= ser_rst_next;
         quad_lane_mode         <= quad_next;
         first_serial_lane_en   <= first_en_next;
         middle_serial_lanes_en <= middle_en_next;
         fourth_serial_lane_en  <= fourth_en_next;
         swing_select           <= swing_next;
      end
   end

   // probe pins and interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_probe_pin_a <= 1'b0;
         timing_probe_pin_b <= 1'b0;
         irq                <= 1'b0;
      end else begin
         timing_probe_pin_a <= probe_a_next;
         timing_probe_pin_b <= probe_b_next;
         irq                <= irq_next;
      end
   end
endmodule

// ==== verification/afe_regs_props.sv ====
`timescale 1ns/1ps
module afe_regs_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // watched controls
   input wire logic        false_lock_in,
   input wire logic        clamp_reference_pin_oe,
   input wire logic [4:0]  clamp_ref_level,
   input wire logic        clamp_ref_code_valid,
   input wire logic        serializer_reset,
   input wire logic        quad_lane_mode,
   input wire logic        first_serial_lane_en,
   input wire logic        middle_serial_lanes_en,
   input wire logic        fourth_serial_lane_en,
   input wire logic        sample_hold_en,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_wr(a);
      s_take ##0 (pwrite && pstrb[0] && paddr == a);
   endsequence
   property p_lane_pair;
      first_serial_lane_en == (middle_serial_lanes_en && quad_lane_mode) && fourth_serial_lane_en == first_serial_lane_en;
   endproperty
   a_lane_pair: assert property (p_lane_pair) else $error("outer lanes do not follow driver and quad mode");
   property p_code_valid;
      clamp_ref_code_valid == (clamp_ref_level <= 5'h1D);
   endproperty
   a_code_valid: assert property (p_code_valid) else $error("clamp code valid flag wrong");
   property p_unused_zero;
      pready |-> prdata[31:8] == 24'h000000;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("upper read data not zero");
   property p_status_read;
      s_take ##0 (!pwrite && paddr == 8'h1C) |=> pready && prdata == {31'h00000000, $past(false_lock_in, 2)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("lock status read wrong");
   property p_unmapped_err;
      s_take ##0 (paddr[1:0] != 2'b00 || paddr[7:6] != 2'b00) |=> pready && pslverr && prdata == 32'h00000000;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
   property p_clamp_oe;
      s_wr(8'h10) |=> ##2 clamp_reference_pin_oe == $past(pwdata[5], 3);
   endproperty
   a_clamp_oe: assert property (p_clamp_oe) else $error("clamp pin enable does not follow write");
   property p_ser_cfg;
      s_wr(8'h14) |=> ##2 {serializer_reset, quad_lane_mode} == {$past(pwdata[7], 3), $past(pwdata[3], 3)};
   endproperty
   a_ser_cfg: assert property (p_ser_cfg) else $error("serial reset or lane mode wrong");
   property p_sh_en;
      s_wr(8'h18) |=> ##2 sample_hold_en == $past(pwdata[7], 3);
   endproperty
   a_sh_en: assert property (p_sh_en) else $error("sample hold enable wrong");
   c_clamp_wr: cover property (s_wr(8'h10));
   c_slverr: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind afe_config_status_registers afe_regs_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .false_lock_in, .clamp_reference_pin_oe, .clamp_ref_level,
   .clamp_ref_code_valid, .serializer_reset, .quad_lane_mode, .first_serial_lane_en, .middle_serial_lanes_en,
   .fourth_serial_lane_en, .sample_hold_en, .irq);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   logic        false_lock_in, clamp_even, sample_even, clamp_odd, sample_odd, odd_tag, converter_clock;
   logic [1:0]  trim_a_level, trim_b_level, swing_select, refbuf_level;
   logic [4:0]  clamp_ref_level;
   logic        clamp_ref_buffered, clamp_reference_pin_oe, clamp_ref_code_valid, serializer_reset, quad_lane_mode;
   logic        first_serial_lane_en, middle_serial_lanes_en, fourth_serial_lane_en, sample_hold_en;
   logic        timing_probe_pin_a, timing_probe_pin_b;
   int          bad_count = 0;
   int          compares = 0;
   logic [7:0]  ra [7] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h2C};
   logic [7:0]  rv [7] = '{8'h5B, 8'h74, 8'h0E, 8'h81, 8'h00, 8'h00, 8'h00};
   logic [2:0]  tc [4] = '{3'b000, 3'b001, 3'b011, 3'b111};
   logic [7:0]  sv [4] = '{8'h84, 8'h0F, 8'h0A, 8'h01};
   logic [6:0]  se [4] = '{7'h48, 7'h3F, 7'h22, 7'h01};
   logic [7:0]  hv [4] = '{8'h80, 8'h02, 8'h04, 8'h86};
   logic [2:0]  he [4] = '{3'h4, 3'h1, 3'h1, 3'h6};
   logic [1:0]  pe [4] = '{2'h0, 2'h2, 2'h1, 2'h3};

   afe_config_status_registers i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .false_lock_in, .clamp_even, .sample_even, .clamp_odd, .sample_odd, .odd_tag,
      .converter_clock, .trim_a_level, .trim_b_level, .clamp_ref_buffered, .clamp_reference_pin_oe,
      .clamp_ref_level, .clamp_ref_code_valid, .serializer_reset, .quad_lane_mode, .first_serial_lane_en,
      .middle_serial_lanes_en, .fourth_serial_lane_en, .swing_select, .sample_hold_en, .refbuf_level,
      .timing_probe_pin_a, .timing_probe_pin_b, .irq);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic print_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer, held until pready, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(negedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h00000000);
      chk("prdata", rdat, {24'h000000, e});
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      {false_lock_in, clamp_even, sample_even, clamp_odd, sample_odd, odd_tag, converter_clock} = 7'b0100111;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 4; i++) begin
         wr(8'h0C, {2'b01, tc[i], tc[i]});
         chk("trim", 32'({trim_a_level, trim_b_level}), 32'({i[1:0], i[1:0]}));
      end
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h7F);
      chk("clamp", 32'({clamp_ref_buffered, clamp_reference_pin_oe, clamp_ref_level, clamp_ref_code_valid}), 32'hFE);
      wr(8'h10, 8'h1D);
      chk("clamp", 32'({clamp_ref_buffered, clamp_reference_pin_oe, clamp_ref_level, clamp_ref_code_valid}), 32'h3B);
      for (int i = 0; i < 4; i++) begin
         wr(8'h14, sv[i]);
         repeat (5) @(posedge pclk);
         chk("serial", 32'({serializer_reset, quad_lane_mode, first_serial_lane_en, middle_serial_lanes_en,
             fourth_serial_lane_en, swing_select}), 32'(se[i]));
      end
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'h8F);
      for (int i = 0; i < 4; i++) begin
         wr(8'h18, hv[i]);
         chk("sample_hold", 32'({sample_hold_en, refbuf_level}), 32'(he[i]));
      end
      wr(8'h18, 8'hFF);
      rd(8'h18, 8'h87);
      for (int i = 0; i < 4; i++) begin
         wr(8'h24, {3'b000, i[1:0], 3'b000});
         chk("probe", 32'({timing_probe_pin_a, timing_probe_pin_b}), 32'(pe[i]));
      end
      false_lock_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("irq", 32'(irq), 32'h0);
      wr(8'h1C, 8'h00);
      rd(8'h1C, 8'h01);
      rd(8'h28, 8'h01);
      rd(8'h28, 8'h00);
      wr(8'h2C, 8'h01);
      false_lock_in <= 1'b0;
      repeat (3) @(posedge pclk);
      false_lock_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("irq", 32'(irq), 32'h1);
      rd(8'h28, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq", 32'(irq), 32'h0);
      apb(1'b0, 8'h08, 32'h00000000);
      chk("pslverr", 32'(err), 32'h1);
      apb(1'b1, 8'h0D, 32'h000000FF);
      chk("pslverr", 32'(err), 32'h1);
      print_verdict;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      print_verdict;
   end
endmodule
